// File: rtl/fan_mux_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef FAN_MUX_REGS_SVH
`define FAN_MUX_REGS_SVH

// register indices: the byte address is four times the index
`define IDX_DUTY1       8'h30
`define IDX_DUTY2       8'h31
`define IDX_DUTY3       8'h32
`define IDX_CFG1        8'h5c
`define IDX_CFG2        8'h5d
`define IDX_CFG3        8'h5e
`define IDX_SLOPE1      8'h5f
`define IDX_SLOPE2      8'h60
`define IDX_SLOPE3      8'h61
`define IDX_ACOUSTIC    8'h62
`define IDX_FLOOR1      8'h64
`define IDX_FLOOR2      8'h65
`define IDX_FLOOR3      8'h66
`define IDX_TMIN1       8'h67
`define IDX_TMIN2       8'h68
`define IDX_TMIN3       8'h69
`define IDX_HYST_A      8'h6d
`define IDX_HYST_B      8'h6e

// reset values
`define RST_DUTY        8'hff
`define RST_CFG         8'h60
`define RST_SLOPE       8'hc4
`define RST_ACOUSTIC    8'h00
`define RST_FLOOR       8'h80
`define RST_TMIN        8'h5a
`define RST_HYST_A      8'h44
`define RST_HYST_B      8'h40

// field positions
`define FAN_BEHAVIOUR_SELECT_MSB        7
`define FAN_BEHAVIOUR_SELECT_LSB        5
`define INV_BIT         4
`define SLOPE_MSB       7
`define SLOPE_LSB       4
`define KEEP_LSB        5

// duty levels and timing
`define DUTY_FULL       8'hff
`define DUTY_ZERO       8'h00
`define SPIN_EDGES      2'd2
`define PWM_TICK_DIV    16'd100

`endif

// File: rtl/fan_mux_pkg.sv
// types shared by the fan control mux
package fan_mux_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        FAN_BEHAVIOUR_SELECT_REMOTE1 = 3'b000,
        FAN_BEHAVIOUR_SELECT_LOCAL   = 3'b001,
        FAN_BEHAVIOUR_SELECT_REMOTE2 = 3'b010,
        FAN_BEHAVIOUR_SELECT_FULL    = 3'b011,
        FAN_BEHAVIOUR_SELECT_OFF     = 3'b100,
        FAN_BEHAVIOUR_SELECT_FAST2   = 3'b101,
        FAN_BEHAVIOUR_SELECT_FAST3   = 3'b110,
        FAN_BEHAVIOUR_SELECT_MANUAL  = 3'b111
    } behaviour_e;

    typedef struct packed {
        logic [2:0][7:0] manual;
        logic [2:0][7:0] cfg;
        logic [2:0][7:0] slope;
        logic [2:0][7:0] floor_duty;
        logic [2:0][7:0] tmin;
        logic [7:0]      hyst_a;
        logic [7:0]      hyst_b;
        logic [7:0]      acoustic;
        logic [2:0]      chan_on;
        logic [2:0][7:0] duty;
        logic [2:0]      spin;
        logic [2:0][1:0] edges;
        logic [2:0]      fan_speed_pulse_prev;
        logic [7:0]      pwm_cnt;
        logic [15:0]     div_cnt;
        logic [2:0]      pwm_out;
        logic [31:0]     prdata;
        logic            pslverr;
    } state_s;

endpackage

// File: rtl/auto_fan_control_mux.sv
// automatic fan control mux: three channels, three fan drive outputs
`include "fan_mux_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - codes 000/001/010 take duty from remote 1, local or remote 2
// - code 101 drives the larger of local and remote 2 demands
// - code 110 drives the largest of all three channel demands
// - code 011 is full speed and the reset value; 100 disables
// - code 111 makes the duty register writable and drive directly
// - each channel computes its own demand before the maximum is taken
// - each channel has an 8-bit two's complement turn-on temperature
// - at turn-on temperature the fan runs at its floor duty
// - fan stops below turn-on minus hysteresis unless keep-running set
// - a starting fan in an automatic mode runs at full until two speed pulse edges
// - acoustic bits 7..5 keep outputs 3..1 at floor when off
// - each output has an 8-bit floor duty register
// - outputs on one channel share turn-on but use own floor
// - duty rises by 170/slope per degree, reaching 255 at full point
// - slope code sits in bits 7:4 of the slope register, reset 1100
// - per-channel 4-bit off hysteresis, reset 4 degrees
// - duty register reads return the duty actually driven
module auto_fan_control_mux (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire fan_mux_pkg::byte_t TEMP_REMOTE1,
    input  wire fan_mux_pkg::byte_t TEMP_LOCAL,
    input  wire fan_mux_pkg::byte_t TEMP_REMOTE2,
    input  wire logic [2:0]  FAN_SPEED_PULSE,
    output logic      [2:0]  FAN_DRIVE_OUTPUT,
    output logic      [23:0] FAN_DUTY
);
    import fan_mux_pkg::*;

    state_s s_q;
    state_s s_d;

    ////////////////////////////////////////////////////////////////////////
    // per-degree duty step times 16 for each slope code; 170/slope is
    // exact in sixteenths for every code, so no rounding drift
    function automatic logic [10:0] slope_rate(input logic [3:0] code);
        logic [10:0] r;
        r = 11'd0;
        unique case (code)
            4'h0: r = 11'd1360;
            4'h1: r = 11'd1088;
            4'h2: r = 11'd816;
            4'h3: r = 11'd680;
            4'h4: r = 11'd544;
            4'h5: r = 11'd408;
            4'h6: r = 11'd340;
            4'h7: r = 11'd272;
            4'h8: r = 11'd204;
            4'h9: r = 11'd170;
            4'ha: r = 11'd136;
            4'hb: r = 11'd102;
            4'hc: r = 11'd85;
            4'hd: r = 11'd68;
            4'he: r = 11'd51;
            4'hf: r = 11'd34;
        endcase
        return r;
    endfunction

    // signed distance of temperature above turn-on point
    function automatic logic signed [9:0] temp_delta(input byte_t t,
                                                     input byte_t tmin);
        return 10'(signed'(t)) - 10'(signed'(tmin));
    endfunction

    function automatic byte_t ramp_duty(input logic signed [9:0] delta,
                                        input byte_t floor_duty,
                                        input logic [3:0] code);
        logic [19:0] prod;
        logic [16:0] sum;
        byte_t       res;
        prod = 20'd0;
        sum  = 17'd0;
        res  = floor_duty;
        if (delta > 10'sd0) begin
            prod = 20'(delta[8:0]) * 20'(slope_rate(code));
            sum  = 17'(floor_duty) + 17'(prod[19:4]);
            res  = (sum > 17'(`DUTY_FULL)) ? `DUTY_FULL : sum[7:0];
        end
        return res;
    endfunction

    function automatic byte_t max2(input byte_t a, input byte_t b);
        return (a > b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    byte_t             temp     [3];
    logic        [3:0] hyst     [3];
    logic signed [9:0] delta    [3];
    logic        [2:0] on_now;
    byte_t             demand   [3][3];
    byte_t             auto_d   [3];
    logic        [2:0] is_auto;
    logic        [2:0] fan_speed_pulse_rise;
    logic        [7:0] idx;
    logic              mapped;
    logic              addr_ok;
    logic        [31:0] rdata;
    behaviour_e        fan_behaviour_select     [3];

    always_comb begin
        s_d = s_q;
        temp[0] = TEMP_REMOTE1;
        temp[1] = TEMP_LOCAL;
        temp[2] = TEMP_REMOTE2;
        hyst[0] = s_q.hyst_a[7:4];
        hyst[1] = s_q.hyst_a[3:0];
        hyst[2] = s_q.hyst_b[7:4];

        // channel on/off with hysteresis, one flag per channel
        for (int c = 0; c < 3; c++) begin
            delta[c]  = temp_delta(temp[c], s_q.tmin[c]);
            on_now[c] = s_q.chan_on[c];
            if (delta[c] > 10'sd0) begin
                on_now[c] = 1'b1;
            end else if (delta[c] < -10'(signed'({1'b0, hyst[c]}))) begin
                on_now[c] = 1'b0;
            end
        end
        s_d.chan_on = on_now;

        // each output computes a demand from every channel separately
        for (int o = 0; o < 3; o++) begin
            for (int c = 0; c < 3; c++) begin
                if (on_now[c]) begin
                    demand[o][c] = ramp_duty(delta[c], s_q.floor_duty[o],
                        s_q.slope[c][`SLOPE_MSB:`SLOPE_LSB]);
                end else if (s_q.acoustic[`KEEP_LSB + o]) begin
                    demand[o][c] = s_q.floor_duty[o];
                end else begin
                    demand[o][c] = `DUTY_ZERO;
                end
            end
        end

        for (int o = 0; o < 3; o++) begin
            fan_behaviour_select[o]    = behaviour_e'(s_q.cfg[o][`FAN_BEHAVIOUR_SELECT_MSB:`FAN_BEHAVIOUR_SELECT_LSB]);
            auto_d[o]  = `DUTY_ZERO;
            is_auto[o] = 1'b1;
            unique case (fan_behaviour_select[o])
                FAN_BEHAVIOUR_SELECT_REMOTE1: auto_d[o] = demand[o][0];
                FAN_BEHAVIOUR_SELECT_LOCAL:   auto_d[o] = demand[o][1];
                FAN_BEHAVIOUR_SELECT_REMOTE2: auto_d[o] = demand[o][2];
                FAN_BEHAVIOUR_SELECT_FAST2:   auto_d[o] = max2(demand[o][1],
                                               demand[o][2]);
                FAN_BEHAVIOUR_SELECT_FAST3:   auto_d[o] = max2(max2(demand[o][0],
                                  demand[o][1]), demand[o][2]);
                FAN_BEHAVIOUR_SELECT_FULL: begin
                    auto_d[o]  = `DUTY_FULL;
                    is_auto[o] = 1'b0;
                end
                FAN_BEHAVIOUR_SELECT_OFF: begin
                    auto_d[o]  = `DUTY_ZERO;
                    is_auto[o] = 1'b0;
                end
                FAN_BEHAVIOUR_SELECT_MANUAL: begin
                    auto_d[o]  = s_q.manual[o];
                    is_auto[o] = 1'b0;
                end
            endcase
        end

        // spin-up of a stopped fan in automatic modes: full drive until two speed edges
        fan_speed_pulse_rise = FAN_SPEED_PULSE & ~s_q.fan_speed_pulse_prev;
        s_d.fan_speed_pulse_prev = FAN_SPEED_PULSE;
        for (int o = 0; o < 3; o++) begin
            s_d.duty[o] = auto_d[o];
            if (!is_auto[o] || auto_d[o] == `DUTY_ZERO) begin
                s_d.spin[o]  = 1'b0;
                s_d.edges[o] = 2'd0;
            end else if (s_q.spin[o]) begin
                s_d.duty[o] = `DUTY_FULL;
                if (fan_speed_pulse_rise[o]) begin
                    s_d.edges[o] = s_q.edges[o] + 2'd1;
                    if (s_q.edges[o] + 2'd1 == `SPIN_EDGES) begin
                        s_d.spin[o]  = 1'b0;
                        s_d.edges[o] = 2'd0;
                        s_d.duty[o]  = auto_d[o];
                    end
                end
            end else if (s_q.duty[o] == `DUTY_ZERO) begin
                s_d.spin[o]  = 1'b1;
                s_d.edges[o] = 2'd0;
                s_d.duty[o]  = `DUTY_FULL;
            end
        end

        // pwm waveform, advanced by a divided tick
        if (s_q.div_cnt == `PWM_TICK_DIV - 16'd1) begin
            s_d.div_cnt = 16'd0;
            s_d.pwm_cnt = s_q.pwm_cnt + 8'd1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 16'd1;
        end
        for (int o = 0; o < 3; o++) begin
            s_d.pwm_out[o] = ((s_q.pwm_cnt < s_q.duty[o]) ||
                              (s_q.duty[o] == `DUTY_FULL))
                             ^ s_q.cfg[o][`INV_BIT];
        end

        ////////////////////////////////////////////////////////////////////
        // register access: decode in setup phase, write in access phase
        idx     = PADDR[9:2];
        addr_ok = (PADDR[1:0] == 2'b00) && (PADDR[11:10] == 2'b00);
        mapped  = 1'b1;
        rdata   = 32'h0000_0000;
        unique case (idx)
            `IDX_DUTY1:    rdata[7:0] = s_q.duty[0];
            `IDX_DUTY2:    rdata[7:0] = s_q.duty[1];
            `IDX_DUTY3:    rdata[7:0] = s_q.duty[2];
            `IDX_CFG1:     rdata[7:0] = s_q.cfg[0];
            `IDX_CFG2:     rdata[7:0] = s_q.cfg[1];
            `IDX_CFG3:     rdata[7:0] = s_q.cfg[2];
            `IDX_SLOPE1:   rdata[7:0] = s_q.slope[0];
            `IDX_SLOPE2:   rdata[7:0] = s_q.slope[1];
            `IDX_SLOPE3:   rdata[7:0] = s_q.slope[2];
            `IDX_ACOUSTIC: rdata[7:0] = s_q.acoustic;
            `IDX_FLOOR1:   rdata[7:0] = s_q.floor_duty[0];
            `IDX_FLOOR2:   rdata[7:0] = s_q.floor_duty[1];
            `IDX_FLOOR3:   rdata[7:0] = s_q.floor_duty[2];
            `IDX_TMIN1:    rdata[7:0] = s_q.tmin[0];
            `IDX_TMIN2:    rdata[7:0] = s_q.tmin[1];
            `IDX_TMIN3:    rdata[7:0] = s_q.tmin[2];
            `IDX_HYST_A:   rdata[7:0] = s_q.hyst_a;
            `IDX_HYST_B:   rdata[7:0] = s_q.hyst_b;
            default:       mapped = 1'b0;
        endcase
        mapped = mapped && addr_ok;

        if (PSEL && !PENABLE) begin
            s_d.prdata  = (mapped && !PWRITE) ? rdata : 32'h0000_0000;
            s_d.pslverr = !mapped;
        end

        if (PSEL && PENABLE && PWRITE && mapped) begin
            unique case (idx)
                `IDX_DUTY1, `IDX_DUTY2, `IDX_DUTY3: begin
                    // writes land only while the output is in manual
                    for (int o = 0; o < 3; o++) begin
                        if (idx == `IDX_DUTY1 + 8'(o) &&
                            fan_behaviour_select[o] == FAN_BEHAVIOUR_SELECT_MANUAL) begin
                            s_d.manual[o] = PWDATA[7:0];
                        end
                    end
                end
                `IDX_CFG1:     s_d.cfg[0] = PWDATA[7:0];
                `IDX_CFG2:     s_d.cfg[1] = PWDATA[7:0];
                `IDX_CFG3:     s_d.cfg[2] = PWDATA[7:0];
                `IDX_SLOPE1:   s_d.slope[0] = PWDATA[7:0];
                `IDX_SLOPE2:   s_d.slope[1] = PWDATA[7:0];
                `IDX_SLOPE3:   s_d.slope[2] = PWDATA[7:0];
                `IDX_ACOUSTIC: s_d.acoustic = PWDATA[7:0];
                `IDX_FLOOR1:   s_d.floor_duty[0] = PWDATA[7:0];
                `IDX_FLOOR2:   s_d.floor_duty[1] = PWDATA[7:0];
                `IDX_FLOOR3:   s_d.floor_duty[2] = PWDATA[7:0];
                `IDX_TMIN1:    s_d.tmin[0] = PWDATA[7:0];
                `IDX_TMIN2:    s_d.tmin[1] = PWDATA[7:0];
                `IDX_TMIN3:    s_d.tmin[2] = PWDATA[7:0];
                `IDX_HYST_A:   s_d.hyst_a = PWDATA[7:0];
                `IDX_HYST_B:   s_d.hyst_b = PWDATA[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_q            <= '0;
            s_q.manual     <= {3{`RST_DUTY}};
            s_q.cfg        <= {3{`RST_CFG}};
            s_q.slope      <= {3{`RST_SLOPE}};
            s_q.floor_duty <= {3{`RST_FLOOR}};
            s_q.tmin       <= {3{`RST_TMIN}};
            s_q.hyst_a     <= `RST_HYST_A;
            s_q.hyst_b     <= `RST_HYST_B;
            s_q.acoustic   <= `RST_ACOUSTIC;
            s_q.duty       <= {3{`RST_DUTY}};
        end else begin
            s_q <= s_d;
        end
    end

    assign PREADY           = 1'b1;
    assign PRDATA           = s_q.prdata;
    assign PSLVERR          = s_q.pslverr && PSEL && PENABLE;
    assign FAN_DRIVE_OUTPUT = s_q.pwm_out;
    assign FAN_DUTY         = s_q.duty;

endmodule // auto_fan_control_mux

// File: test/fan_model.sv
// behavioural cooling fan that returns speed pulses while it is driven
module fan_model (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic [7:0] duty,
    output logic            pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0;
    // a stopped fan gives no edges; stall mimics a seized rotor
    always_ff @(posedge clk) begin
        if (duty == 8'h00 || stall) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // the line sits low whenever the rotor stands still
    assign pulse = cnt_q[3];
endmodule // fan_model

// File: test/auto_fan_control_mux_sva.sv
// concurrent checks on the ports of the fan control mux
module fan_mux_checker (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [2:0]  FAN_DRIVE_OUTPUT,
    input wire logic [23:0] FAN_DUTY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    reset_full_a: assert property ($past(SYS_RST) |->
        FAN_DUTY == 24'hffffff && FAN_DRIVE_OUTPUT == 3'b000)
        else $error("fans not at full speed after reset");
    duty1_read_a: assert property (PSEL && !PENABLE && !PWRITE &&
        PADDR == 12'h0c0 |=> PRDATA[7:0] == $past(FAN_DUTY[7:0]))
        else $error("duty 1 read differs from driven duty");
    duty3_read_a: assert property (PSEL && !PENABLE && !PWRITE &&
        PADDR == 12'h0c8 |=> PRDATA[7:0] == $past(FAN_DUTY[23:16]))
        else $error("duty 3 read differs from driven duty");
    rdata_hold_a: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved outside a setup cycle");
    ready_high_a: assert property (PREADY) else $error("wait state seen");
    rdata_upper_a: assert property (PRDATA[31:8] == 24'h000000)
        else $error("upper read data bits set");
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error flag outside access phase");
    err_rdata_a: assert property (PSEL && PENABLE && !PWRITE && PSLVERR
        |-> PRDATA == 32'h00000000) else $error("refused read not zero");
    misalign_err_a: assert property (PSEL && PENABLE && PADDR[1:0] != 2'b00
        |-> PSLVERR) else $error("misaligned access not refused");
    range_err_a: assert property (PSEL && PENABLE && PADDR[11:10] != 2'b00
        |-> PSLVERR) else $error("out of range access not refused");
endmodule // fan_mux_checker

// File: test/auto_fan_control_mux_bench.sv
// self-checking bench for the automatic fan control mux
`include "fan_mux_regs.svh"
module auto_fan_control_mux_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  temp_in [3];
    logic        stall;
    logic [2:0]  speed_pulse;
    logic [2:0]  drive;
    logic [23:0] duty;
    int          num_errors = 0;
    int          n_tests = 0;
    // model: per channel tm sl hy t on, per output fl kp bh mn
    int          tm[3], sl[3], hy[3], t[3], on[3];
    int          fl[3], kp[3], bh[3], mn[3], iv[3];
    int          rate[16] = '{1360, 1088, 816, 680, 544, 408, 340, 272,
                              204, 170, 136, 102, 85, 68, 51, 34};
    int          ri[8] = '{8'h30, 8'h5c, 8'h5f, 8'h62, 8'h64, 8'h67,
                           8'h6d, 8'h6e};
    int          rv[8] = '{8'hff, 8'h60, 8'hc4, 8'h00, 8'h80, 8'h5a,
                           8'h44, 8'h40};
    logic [11:0] bad[3] = '{12'h18c, 12'h0c1, 12'h400};
    auto_fan_control_mux u_auto_fan_control_mux (
        .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TEMP_REMOTE1(temp_in[0]),
        .TEMP_LOCAL(temp_in[1]), .TEMP_REMOTE2(temp_in[2]),
        .FAN_SPEED_PULSE(speed_pulse), .FAN_DRIVE_OUTPUT(drive),
        .FAN_DUTY(duty));
    for (genvar g = 0; g < 3; g++) begin : g_fan
        fan_model u_fan_model (.clk(clk), .stall(stall),
            .duty(duty[g*8 +: 8]), .pulse(speed_pulse[g]));
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(logic [11:0] a, logic w, logic [7:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(int i, logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb({2'b00, 8'(i), 2'b00}, 1'b1, d, r, e);
    endtask
    function automatic int mx(int a, int b);
        return a > b ? a : b;
    endfunction
    // demand of one channel for one output; floor and keep are per output
    function automatic int dem(int o, int c);
        int v;
        if (!on[c]) return kp[o] ? fl[o] : 0;
        if (t[c] <= tm[c]) return fl[o];
        v = fl[o] + (((t[c] - tm[c]) * rate[sl[c]]) >>> 4);
        return v > 255 ? 255 : v;
    endfunction
    function automatic int expd(int o);
        case (bh[o])
            0, 1, 2: return dem(o, bh[o]);
            3: return 255;
            5: return mx(dem(o, 1), dem(o, 2));
            6: return mx(dem(o, 0), mx(dem(o, 1), dem(o, 2)));
            7: return mn[o];
            default: return 0;
        endcase
    endfunction
    // on-state only moves outside the hysteresis band
    task automatic settemp();
        for (int c = 0; c < 3; c++) begin
            temp_in[c] <= 8'(t[c]);
            if (t[c] > tm[c]) on[c] = 1;
            else if (t[c] < tm[c] - hy[c]) on[c] = 0;
        end
    endtask
    task automatic cmp_all();
        logic [31:0] r;
        logic e;
        for (int o = 0; o < 3; o++) begin
            chk("fan_duty", expd(o), 32'(duty[o*8 +: 8]));
            apb({2'b00, 8'(`IDX_DUTY1 + o), 2'b00}, 1'b0, 8'h00, r, e);
            chk("duty_reg", expd(o), r);
            if (expd(o) == 255) chk("drive", 1 ^ iv[o], 32'(drive[o]));
            if (expd(o) == 0) chk("drive", iv[o], 32'(drive[o]));
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        void'($urandom(8));
        {sys_rst, psel, penable, pwrite, stall} = 5'b10000;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        t = '{-100, -100, -100};
        bh = '{3, 3, 3};
        mn = '{255, 255, 255};
        settemp();
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb({2'b00, 8'(ri[i]), 2'b00}, 1'b0, 8'h00, r, e);
            chk("reset_value", rv[i], r);
        end
        foreach (bad[i]) begin
            apb(bad[i], 1'b1, 8'h5a, r, e);
            apb(bad[i], 1'b0, 8'h00, r, e);
            chk("refused_err", 1, 32'(e));
            chk("refused_data", 0, r);
        end
        // a duty write outside manual mode must not reach the manual value
        wr(`IDX_DUTY1, 8'h12);
        wr(`IDX_CFG1, 8'he0);
        repeat (2) @(posedge clk);
        chk("manual_locked", 255, 32'(duty[7:0]));
        $display("test reset and decode done");
        // negative turn-on temperature exercises the signed compare
        tm = '{40, -10, 60};
        fl = '{64, 26, 128};
        sl = '{12, 0, 15};
        hy = '{3, 15, 1};
        kp = '{1, 0, 1};
        for (int o = 0; o < 3; o++) begin
            wr(`IDX_TMIN1 + o, 8'(tm[o]));
            wr(`IDX_FLOOR1 + o, 8'(fl[o]));
            wr(`IDX_SLOPE1 + o, {4'(sl[o]), 4'h4});
        end
        wr(`IDX_HYST_A, 8'h3f);
        wr(`IDX_HYST_B, 8'h10);
        wr(`IDX_ACOUSTIC, 8'ha0);
        wr(`IDX_CFG1, 8'h80);
        repeat (2) @(posedge clk);
        chk("disabled", 0, 32'(duty[7:0]));
        stall <= 1'b1;
        t[0] = 50;
        settemp();
        wr(`IDX_CFG1, 8'h00);
        bh[0] = 0;
        repeat (60) @(posedge clk);
        chk("spin_stalled", 255, 32'(duty[7:0]));
        apb({2'b00, `IDX_DUTY1, 2'b00}, 1'b0, 8'h00, r, e);
        chk("spin_read", 255, r);
        stall <= 1'b0;
        repeat (100) @(posedge clk);
        cmp_all();
        $display("test spin-up done");
        for (int i = 0; i < 40; i++) begin
            for (int o = 0; o < 3; o++) begin
                bh[o] = $urandom_range(7);
                iv[o] = $urandom_range(1);
                wr(`IDX_CFG1 + o, {3'(bh[o]), 1'(iv[o]), 4'h0});
                r = $urandom;
                wr(`IDX_DUTY1 + o, r[7:0]);
                if (bh[o] == 7) mn[o] = r[7:0];
            end
            for (int c = 0; c < 3; c++) t[c] = tm[c] + $urandom_range(60) - 30;
            settemp();
            repeat (100) @(posedge clk);
            cmp_all();
        end
        $display("test random modes done");
        tally_and_finish();
    end
    initial begin
        #800000;
        num_errors++;
        tally_and_finish();
    end
endmodule // auto_fan_control_mux_bench

bind auto_fan_control_mux fan_mux_checker u_fan_mux_checker (
    .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FAN_DRIVE_OUTPUT(FAN_DRIVE_OUTPUT),
    .FAN_DUTY(FAN_DUTY));
